// *** core/ssl_regs.vh ***
// Purpose: constants for the speed setpoint limiter
// Assumes: speeds are signed 32-bit counts of 0.001 rpm
// Notes: byte offsets on the register bus, one word each
//
// Operation
// - settable positive limit 0..210000 rpm, reset to the maximum
// - positive limit taken from selectable source, default the setting
// - settable negative limit -210000..0 rpm, selectable source
// - vector control clamps limits to 60*240 Hz over pole pairs
// - four skip speeds, default zero, suppress setpoints within bandwidth
// - post-ramp below band and setpoint inside: hold lower edge
// - post-ramp above band and setpoint inside: hold upper edge
// - skip speeds scaled by a selectable percentage source
// - status bit 0 set while post-ramp setpoint is inside a band
// - effective minimum from fixed minimum and selectable source, default zero
// - setpoint after minimum limiting is readable
// - total select high replaces total setpoint by selected source
// - technology controller mode 0 drives total select from its bit 4
// - hibernation drives total select from its status bit 7
// - total value from selectable source, controller output, or hibernation setpoint
// - negative direction inhibit source, default constant 1
// - positive direction inhibit source, default constant 0
// - setpoint sign inverted while inversion source high, default 0
// - maximum speed limits both directions
// - maximum speed write locks parameters until lock state reads 0
// - limits act after the skip stage
// - skip stage fed by direction-limited setpoint, drives ramp input
`ifndef SSL_REGS_VH
`define SSL_REGS_VH
// ************************************************************
// register offsets
// ************************************************************
`define SSL_POS_SET 8'h00
`define SSL_POS_EFF 8'h04
`define SSL_POS_SRC 8'h08
`define SSL_NEG_SET 8'h0C
`define SSL_NEG_EFF 8'h10
`define SSL_NEG_SRC 8'h14
`define SSL_SKIP1 8'h18
`define SSL_SKIP2 8'h1C
`define SSL_SKIP3 8'h20
`define SSL_SKIP4 8'h24
`define SSL_SKIP_SCL_SRC 8'h28
`define SSL_SKIP_FLAGS 8'h2C
`define SSL_SKIP_BW 8'h30
`define SSL_MIN_SRC 8'h34
`define SSL_TSEL_SRC 8'h38
`define SSL_TVAL_SRC 8'h3C
`define SSL_NINH_SRC 8'h40
`define SSL_PINH_SRC 8'h44
`define SSL_AFT_MIN 8'h48
`define SSL_INV_SRC 8'h4C
`define SSL_MAX_SPEED 8'h50
`define SSL_FIX_MIN 8'h54
`define SSL_LOCK 8'h58
`define SSL_RAMP_IN 8'h5C
`define SSL_DIR_LIM 8'h60
`define SSL_CTRL 8'h64
// ************************************************************
// ctrl fields and source codes
// ************************************************************
`define SSL_CTRL_VEC 0
`define SSL_CTRL_TC_SEL 1
`define SSL_CTRL_HIB 2
`define SSL_CTRL_MODE_LO 8
`define SSL_CTRL_MODE_HI 15
`define SSL_SRC_ZERO 2'h0
`define SSL_SRC_SET 2'h1
`define SSL_SRC_EXT 2'h2
`define SSL_BSRC_ZERO 2'h0
`define SSL_BSRC_ONE 2'h1
`define SSL_BSRC_EXT 2'h2
`define SSL_TC_MODE_MAIN 8'h00
// ************************************************************
// reset values and scaling
// ************************************************************
`define SSL_SPEED_MAX 32'h0C845880
`define SSL_SPEED_MIN_NEG 32'hF37BA780
`define SSL_MAX_SPEED_RST 32'h0016E360
`define SSL_PCT_FULL 48'h000000002710
`define SSL_PCT_FULL_W 16'h2710
`define SSL_VEC_HZ 32'h000000F0
`define SSL_RPM_PER_HZ 32'h0000003C
`define SSL_MILLI 32'h000003E8
// ************************************************************
// timing
// ************************************************************
`define SSL_CLK_MHZ 10
`define SSL_LOCK_TIME_US 1000
`define SSL_LOCK_CYCLES (`SSL_LOCK_TIME_US * `SSL_CLK_MHZ)
`define SSL_LOCK_W 20
`endif

// *** core/ssl_top.v ***
// Purpose: speed setpoint limiting stage in front of the ramp generator
// Assumes: all data inputs come from logic on hclk
// Notes: input stage plus output stage, two edges of latency
`include "ssl_regs.vh"
module ssl_top #(
  parameter LOCK_CYCLES = `SSL_LOCK_CYCLES
) (
  // bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // setpoint sources
  input wire [31:0] total_setpoint_in,
  input wire [31:0] ext_pos_limit,
  input wire [31:0] ext_neg_limit,
  input wire [31:0] ext_min_speed,
  input wire [31:0] ext_total_setpoint,
  input wire [15:0] ext_skip_scale,
  input wire ext_total_select,
  input wire ext_neg_inhibit,
  input wire ext_pos_inhibit,
  input wire ext_invert,
  // technology controller and hibernation
  input wire [31:0] techctl_output,
  input wire techctl_status_bit4,
  input wire [31:0] hibernation_setpoint,
  input wire hibernation_status_bit7,
  // motor and ramp generator
  input wire [7:0] pole_pair_count,
  input wire [31:0] post_ramp_setpoint,
  // results
  output reg [31:0] ramp_input_setpoint,
  output reg [31:0] direction_limited_setpoint,
  output reg [31:0] setpoint_after_min_limit,
  output reg [31:0] pos_limit_effective,
  output reg [31:0] neg_limit_effective,
  output reg skip_band_active,
  output reg param_lock_state
);
  // ************************************************************
  // helpers
  // ************************************************************
  function [31:0] src_word;
    input [1:0] sel;
    input [31:0] setting;
    input [31:0] ext;
    begin
      case (sel)
        `SSL_SRC_SET: src_word = setting;
        `SSL_SRC_EXT: src_word = ext;
        default: src_word = 32'h00000000;
      endcase
    end
  endfunction
  function src_bit;
    input [1:0] sel;
    input ext;
    begin
      case (sel)
        `SSL_BSRC_ONE: src_bit = 1'b1;
        `SSL_BSRC_EXT: src_bit = ext;
        default: src_bit = 1'b0;
      endcase
    end
  endfunction
  function signed [31:0] smin;
    input signed [31:0] a;
    input signed [31:0] b;
    begin
      smin = (a < b) ? a : b;
    end
  endfunction
  // ************************************************************
  // settings
  // ************************************************************
  reg [31:0] pos_set_q, neg_set_q, bw_q, max_q, fmin_q, ctrl_q;
  reg [31:0] skip_q [0:3];
  reg [1:0] pos_src_q, neg_src_q, scl_src_q, min_src_q, tsel_src_q, tval_src_q;
  reg [1:0] ninh_src_q, pinh_src_q, inv_src_q;
  reg [`SSL_LOCK_W-1:0] lock_q, lock_d;
  reg wr_q;
  reg [7:0] addr_q;
  reg [31:0] rd_d;
  wire take = hsel & htrans[1] & hready;
  wire wr_ok = wr_q & (lock_q == {`SSL_LOCK_W{1'b0}});
  integer k;
  always @* begin
    lock_d = lock_q;
    if (wr_ok && addr_q == `SSL_MAX_SPEED) begin
      lock_d = LOCK_CYCLES[`SSL_LOCK_W-1:0];
    end else if (lock_q != {`SSL_LOCK_W{1'b0}}) begin
      lock_d = lock_q - 1'b1;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      lock_q <= {`SSL_LOCK_W{1'b0}};
      param_lock_state <= 1'b0;
      pos_set_q <= `SSL_SPEED_MAX;
      neg_set_q <= `SSL_SPEED_MIN_NEG;
      bw_q <= 32'h00000000;
      max_q <= `SSL_MAX_SPEED_RST;
      fmin_q <= 32'h00000000;
      ctrl_q <= 32'h00000000;
      for (k = 0; k < 4; k = k + 1) begin
        skip_q[k] <= 32'h00000000;
      end
      pos_src_q <= `SSL_SRC_SET;
      neg_src_q <= `SSL_SRC_SET;
      scl_src_q <= `SSL_SRC_SET;
      min_src_q <= `SSL_SRC_ZERO;
      tsel_src_q <= `SSL_BSRC_ZERO;
      tval_src_q <= `SSL_SRC_ZERO;
      ninh_src_q <= `SSL_BSRC_ONE;
      pinh_src_q <= `SSL_BSRC_ZERO;
      inv_src_q <= `SSL_BSRC_ZERO;
    end else begin
      wr_q <= take & hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
      lock_q <= lock_d;
      param_lock_state <= (lock_d != {`SSL_LOCK_W{1'b0}});
      if (wr_ok) begin
        case (addr_q)
          `SSL_POS_SET: pos_set_q <= hwdata;
          `SSL_NEG_SET: neg_set_q <= hwdata;
          `SSL_SKIP1: skip_q[0] <= hwdata;
          `SSL_SKIP2: skip_q[1] <= hwdata;
          `SSL_SKIP3: skip_q[2] <= hwdata;
          `SSL_SKIP4: skip_q[3] <= hwdata;
          `SSL_SKIP_BW: bw_q <= hwdata;
          `SSL_MAX_SPEED: max_q <= hwdata;
          `SSL_FIX_MIN: fmin_q <= hwdata;
          `SSL_CTRL: ctrl_q <= hwdata;
          `SSL_POS_SRC: pos_src_q <= hwdata[1:0];
          `SSL_NEG_SRC: neg_src_q <= hwdata[1:0];
          `SSL_SKIP_SCL_SRC: scl_src_q <= hwdata[1:0];
          `SSL_MIN_SRC: min_src_q <= hwdata[1:0];
          `SSL_TSEL_SRC: tsel_src_q <= hwdata[1:0];
          `SSL_TVAL_SRC: tval_src_q <= hwdata[1:0];
          `SSL_NINH_SRC: ninh_src_q <= hwdata[1:0];
          `SSL_PINH_SRC: pinh_src_q <= hwdata[1:0];
          `SSL_INV_SRC: inv_src_q <= hwdata[1:0];
          default: ;
        endcase
      end
    end
  end
  // ************************************************************
  // read mux
  // ************************************************************
  // read data is fetched in the address phase, so a read right after a
  // write to the same word returns the old value
  always @* begin
    case (haddr[7:0])
      `SSL_POS_SET: rd_d = pos_set_q;
      `SSL_POS_EFF: rd_d = pos_limit_effective;
      `SSL_POS_SRC: rd_d = {30'h00000000, pos_src_q};
      `SSL_NEG_SET: rd_d = neg_set_q;
      `SSL_NEG_EFF: rd_d = neg_limit_effective;
      `SSL_NEG_SRC: rd_d = {30'h00000000, neg_src_q};
      `SSL_SKIP1: rd_d = skip_q[0];
      `SSL_SKIP2: rd_d = skip_q[1];
      `SSL_SKIP3: rd_d = skip_q[2];
      `SSL_SKIP4: rd_d = skip_q[3];
      `SSL_SKIP_SCL_SRC: rd_d = {30'h00000000, scl_src_q};
      `SSL_SKIP_FLAGS: rd_d = {31'h00000000, skip_band_active};
      `SSL_SKIP_BW: rd_d = bw_q;
      `SSL_MIN_SRC: rd_d = {30'h00000000, min_src_q};
      `SSL_TSEL_SRC: rd_d = {30'h00000000, tsel_src_q};
      `SSL_TVAL_SRC: rd_d = {30'h00000000, tval_src_q};
      `SSL_NINH_SRC: rd_d = {30'h00000000, ninh_src_q};
      `SSL_PINH_SRC: rd_d = {30'h00000000, pinh_src_q};
      `SSL_AFT_MIN: rd_d = setpoint_after_min_limit;
      `SSL_INV_SRC: rd_d = {30'h00000000, inv_src_q};
      `SSL_MAX_SPEED: rd_d = max_q;
      `SSL_FIX_MIN: rd_d = fmin_q;
      `SSL_LOCK: rd_d = {31'h00000000, param_lock_state};
      `SSL_RAMP_IN: rd_d = ramp_input_setpoint;
      `SSL_DIR_LIM: rd_d = direction_limited_setpoint;
      `SSL_CTRL: rd_d = ctrl_q;
      default: rd_d = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rd_d;
    end
  end
  // ************************************************************
  // input sampling
  // ************************************************************
  reg [31:0] tot_s, epos_s, eneg_s, emin_s, etot_s, tco_s, hsp_s, pr_s;
  reg [15:0] scl_s;
  reg [7:0] pp_s;
  reg esel_s, eninh_s, epinh_s, einv_s, tcb_s, hib_s;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tot_s <= 32'h00000000;
      epos_s <= 32'h00000000;
      eneg_s <= 32'h00000000;
      emin_s <= 32'h00000000;
      etot_s <= 32'h00000000;
      tco_s <= 32'h00000000;
      hsp_s <= 32'h00000000;
      pr_s <= 32'h00000000;
      scl_s <= 16'h0000;
      pp_s <= 8'h00;
      esel_s <= 1'b0;
      eninh_s <= 1'b0;
      epinh_s <= 1'b0;
      einv_s <= 1'b0;
      tcb_s <= 1'b0;
      hib_s <= 1'b0;
    end else begin
      tot_s <= total_setpoint_in;
      epos_s <= ext_pos_limit;
      eneg_s <= ext_neg_limit;
      emin_s <= ext_min_speed;
      etot_s <= ext_total_setpoint;
      tco_s <= techctl_output;
      hsp_s <= hibernation_setpoint;
      pr_s <= post_ramp_setpoint;
      scl_s <= ext_skip_scale;
      pp_s <= pole_pair_count;
      esel_s <= ext_total_select;
      eninh_s <= ext_neg_inhibit;
      epinh_s <= ext_pos_inhibit;
      einv_s <= ext_invert;
      tcb_s <= techctl_status_bit4;
      hib_s <= hibernation_status_bit7;
    end
  end
  // ************************************************************
  // changeover, inversion, direction
  // ************************************************************
  wire tc_on = ctrl_q[`SSL_CTRL_TC_SEL] &
    (ctrl_q[`SSL_CTRL_MODE_HI:`SSL_CTRL_MODE_LO] == `SSL_TC_MODE_MAIN);
  wire hib_on = ctrl_q[`SSL_CTRL_HIB];
  wire tsel = hib_on ? hib_s : (tc_on ? tcb_s : src_bit(tsel_src_q, esel_s));
  wire [31:0] tval = hib_on ? hsp_s :
    (tc_on ? tco_s : src_word(tval_src_q, 32'h00000000, etot_s));
  wire signed [31:0] base = tsel ? tval : tot_s;
  wire signed [31:0] inv = src_bit(inv_src_q, einv_s) ? -base : base;
  wire blk = (src_bit(ninh_src_q, eninh_s) && inv < 0) ||
    (src_bit(pinh_src_q, epinh_s) && inv > 0);
  wire signed [31:0] dlim = blk ? 32'h00000000 : inv;
  // ************************************************************
  // skip bands
  // ************************************************************
  // percent scaling
  wire [15:0] pct = (scl_src_q == `SSL_SRC_SET) ? `SSL_PCT_FULL_W :
    ((scl_src_q == `SSL_SRC_EXT) ? scl_s : 16'h0000);
  wire signed [31:0] lo [0:3];
  wire signed [31:0] hi [0:3];
  wire signed [31:0] ctr [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_band
      wire [47:0] prod = skip_q[g] * pct;
      wire [47:0] scaled = prod / `SSL_PCT_FULL;
      assign ctr[g] = scaled[31:0];
      assign lo[g] = scaled[31:0] - bw_q;
      assign hi[g] = scaled[31:0] + bw_q;
    end
  endgenerate
  wire signed [31:0] prs = pr_s;
  reg signed [31:0] skip_out;
  reg found, pr_in;
  integer i;
  always @* begin
    skip_out = dlim;
    found = 1'b0;
    pr_in = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (prs >= lo[i] && prs <= hi[i]) begin
        pr_in = 1'b1;
      end
      if (!found && dlim >= lo[i] && dlim <= hi[i]) begin
        found = 1'b1;
        if (prs < lo[i]) begin
          skip_out = lo[i];
        end else if (prs > hi[i]) begin
          skip_out = hi[i];
        end else if (dlim < ctr[i]) begin
          skip_out = lo[i];
        end else begin
          skip_out = hi[i];
        end
      end
    end
  end
  // ************************************************************
  // minimum and limits
  // ************************************************************
  // larger of both minima
  wire signed [31:0] msrc = src_word(min_src_q, fmin_q, emin_s);
  wire signed [31:0] fmin = fmin_q;
  wire signed [31:0] mineff = (msrc > fmin) ? msrc : fmin;
  wire signed [31:0] aftmin = (skip_out > 0 && skip_out < mineff) ? mineff :
    ((skip_out < 0 && skip_out > -mineff) ? -mineff : skip_out);
  // vector clamp, zero pole pairs leaves it open
  wire [31:0] vnum = `SSL_RPM_PER_HZ * `SSL_VEC_HZ * `SSL_MILLI;
  wire [31:0] vdiv = vnum / {24'h000000, pp_s};
  wire signed [31:0] vlim = (ctrl_q[`SSL_CTRL_VEC] && pp_s != 8'h00) ? vdiv :
    `SSL_SPEED_MAX;
  wire signed [31:0] psel = src_word(pos_src_q, pos_set_q, epos_s);
  wire signed [31:0] nsel = src_word(neg_src_q, neg_set_q, eneg_s);
  wire signed [31:0] pmag = smin(smin(max_q, psel), vlim);
  wire signed [31:0] nmag = smin(smin(max_q, -nsel), vlim);
  wire signed [31:0] rin = (aftmin > pmag) ? pmag :
    ((aftmin < -nmag) ? -nmag : aftmin);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_input_setpoint <= 32'h00000000;
      direction_limited_setpoint <= 32'h00000000;
      setpoint_after_min_limit <= 32'h00000000;
      pos_limit_effective <= 32'h00000000;
      neg_limit_effective <= 32'h00000000;
      skip_band_active <= 1'b0;
    end else begin
      ramp_input_setpoint <= rin;
      direction_limited_setpoint <= dlim;
      setpoint_after_min_limit <= aftmin;
      pos_limit_effective <= pmag;
      neg_limit_effective <= -nmag;
      skip_band_active <= pr_in;
    end
  end
endmodule // ssl_top

// *** testbench/ssl_props.sv ***
// Purpose: port-level assertions for the setpoint limiter
// Assumes: LOCK_CYCLES is handed on from the bound instance
// Notes: settings held in registers are judged by the bench instead
module ssl_props #(
  parameter int LOCK_CYCLES = 8
) (
  // bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // results
  input wire [31:0] ramp_input_setpoint,
  input wire [31:0] setpoint_after_min_limit,
  input wire [31:0] pos_limit_effective,
  input wire [31:0] neg_limit_effective,
  input wire param_lock_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // counts lock cycles; a counter keeps long spans out of repetitions
  int len_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      len_q <= 0;
    else if (param_lock_state)
      len_q <= len_q + 1;
    else
      len_q <= 0;
  end
  sequence max_wr_s;
    hsel && htrans[1] && hwrite && hready && haddr == 32'h00000050 && !param_lock_state;
  endsequence
  sequence locked_s;
    param_lock_state;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or response not okay");
  a_pos_range: assert property ($signed(pos_limit_effective) >= 0 &&
    $signed(pos_limit_effective) <= $signed(32'h0C845880)) else $error("pos limit range");
  a_neg_range: assert property ($signed(neg_limit_effective) <= 0 &&
    $signed(neg_limit_effective) >= $signed(32'hF37BA780)) else $error("neg limit range");
  a_clamp_upper: assert property (
    $signed(ramp_input_setpoint) <= $signed(pos_limit_effective)) else $error("above pos limit");
  a_clamp_lower: assert property (
    $signed(ramp_input_setpoint) >= $signed(neg_limit_effective)) else $error("below neg limit");
  a_zero_passes: assert property (setpoint_after_min_limit == 32'h0 |->
    ramp_input_setpoint == 32'h0) else $error("zero setpoint altered by limits");
  a_lock_after_write: assert property (max_wr_s |-> ##[1:3] locked_s)
    else $error("max speed write did not lock");
  a_lock_length: assert property ($fell(param_lock_state) |->
    len_q >= LOCK_CYCLES - 1 && len_q <= LOCK_CYCLES + 1) else $error("lock span wrong");
  a_lock_bound: assert property (len_q <= LOCK_CYCLES + 1)
    else $error("lock held too long");
endmodule // ssl_props

bind ssl_top ssl_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_ssl_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .ramp_input_setpoint,
  .setpoint_after_min_limit, .pos_limit_effective, .neg_limit_effective, .param_lock_state);

// *** testbench/ssl_ramp_model.sv ***
// Purpose: ramp generator standing after the limiter
// Assumes: one clock shared with the limiter
// Notes: hold pins the output so skip hysteresis can be set up exactly
module ssl_ramp_model #(
  parameter logic [31:0] STEP = 32'h0000C350
) (
  // clock
  input wire hclk,
  input wire hresetn,
  // ramp side
  input wire [31:0] ramp_in,
  input wire hold,
  input wire [31:0] hold_val,
  output logic [31:0] post_ramp
);
  timeunit 1ns;
  timeprecision 1ns;
  // follows the limited ramp input setpoint at a bounded slope
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      post_ramp <= 32'h0;
    else if (hold)
      post_ramp <= hold_val;
    else if ($signed(ramp_in) > $signed(post_ramp + STEP))
      post_ramp <= post_ramp + STEP;
    else if ($signed(ramp_in) < $signed(post_ramp - STEP))
      post_ramp <= post_ramp - STEP;
    else
      post_ramp <= ramp_in;
  end
endmodule // ssl_ramp_model

// *** testbench/ssl_top_bench.sv ***
// Purpose: self-checking bench for the setpoint limiter
// Assumes: zero wait state slave, two edges of datapath latency
// Notes: lock span shortened to 8 cycles to keep the run short
module ssl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCKN = 8;
  logic hclk, hresetn, hsel, hwrite, hold, e_sel, e_ninh, e_pinh, e_inv, tc_b4, hib_b7;
  logic [1:0] htrans;
  logic [7:0] pp;
  logic [15:0] e_scale;
  logic [31:0] haddr, hwdata, tot, e_pos, e_neg, e_min, e_tot, tc_out, hib_sp, hold_val;
  wire [31:0] hrdata, ramp_in, dlim, aft_min, pos_eff, neg_eff, post_ramp;
  wire hreadyout, hresp, skip_flag, lock;
  int miscompares, tests_run;
  ssl_top #(.LOCK_CYCLES(LOCKN)) u_ssl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .total_setpoint_in(tot), .ext_pos_limit(e_pos), .ext_neg_limit(e_neg),
    .ext_min_speed(e_min), .ext_total_setpoint(e_tot), .ext_skip_scale(e_scale),
    .ext_total_select(e_sel), .ext_neg_inhibit(e_ninh), .ext_pos_inhibit(e_pinh),
    .ext_invert(e_inv), .techctl_output(tc_out), .techctl_status_bit4(tc_b4),
    .hibernation_setpoint(hib_sp), .hibernation_status_bit7(hib_b7), .pole_pair_count(pp),
    .post_ramp_setpoint(post_ramp), .ramp_input_setpoint(ramp_in),
    .direction_limited_setpoint(dlim), .setpoint_after_min_limit(aft_min),
    .pos_limit_effective(pos_eff), .neg_limit_effective(neg_eff),
    .skip_band_active(skip_flag), .param_lock_state(lock));
  ssl_ramp_model u_ssl_ramp_model (.hclk(hclk), .hresetn(hresetn), .ramp_in(ramp_in),
    .hold(hold), .hold_val(hold_val), .post_ramp(post_ramp));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t bus hang", $time);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e, what);
  endtask
  // new total setpoint, then ramp input checked after the pipeline
  task automatic drv(input logic [31:0] t, e, input string what);
    @(posedge hclk);
    tot <= t;
    repeat (4) @(posedge hclk);
    #10;
    check(ramp_in, e, what);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(32'h00, 32'h0C845880, "pos set");
    rd(32'h0C, 32'hF37BA780, "neg set");
    rd(32'h50, 32'h0016E360, "max speed");
    rd(32'h08, 32'h1, "pos src");
    rd(32'h40, 32'h1, "neg inh src");
    rd(32'h44, 32'h0, "pos inh src");
    rd(32'h4C, 32'h0, "inv src");
    rd(32'h34, 32'h0, "min src");
    rd(32'h24, 32'h0, "skip four");
    wr(32'h04, 32'h00000001);
    rd(32'h04, 32'h0016E360, "pos eff ro");
    wr(32'hFC, 32'h00000055);
    rd(32'hFC, 32'h0, "unmapped");
  endtask
  task automatic t_limits;
    drv(32'h001E8480, 32'h0016E360, "max clamp");
    wr(32'h08, 32'h2);
    drv(32'h001E8480, 32'h000F4240, "ext pos");
    check(pos_eff, 32'h000F4240, "pos eff");
    wr(32'h40, 32'h0);
    drv(32'hFFD23940, 32'hFFE91CA0, "max neg");
    wr(32'h14, 32'h2);
    drv(32'hFFD23940, 32'hFFF551A0, "ext neg");
    wr(32'h08, 32'h1);
    wr(32'h64, 32'h1);
    drv(32'h001E8480, 32'h000DBBA0, "vector pos");
    check(neg_eff, 32'hFFF551A0, "neg eff kept");
    wr(32'h14, 32'h1);
    drv(32'hFFD23940, 32'hFFF24460, "vector neg");
    wr(32'h64, 32'h0);
  endtask
  task automatic t_dir;
    wr(32'h40, 32'h1);
    drv(32'hFFF85EE0, 32'h0, "neg blocked");
    wr(32'h40, 32'h2);
    drv(32'hFFF85EE0, 32'hFFF85EE0, "neg ext off");
    check(dlim, 32'hFFF85EE0, "dir limited");
    wr(32'h44, 32'h1);
    drv(32'h0007A120, 32'h0, "pos blocked");
    wr(32'h44, 32'h0);
    wr(32'h4C, 32'h2);
    drv(32'h0007A120, 32'hFFF85EE0, "inverted");
    wr(32'h4C, 32'h0);
  endtask
  task automatic t_total;
    wr(32'h3C, 32'h2);
    wr(32'h38, 32'h1);
    drv(32'h000186A0, 32'h00061A80, "total ext");
    wr(32'h38, 32'h2);
    drv(32'h000186A0, 32'h000186A0, "total intern");
    // configuration keeps the automatic links while they feed
    wr(32'h64, 32'h2);
    drv(32'h000186A0, 32'h000493E0, "techctl");
    wr(32'h64, 32'h00000102);
    drv(32'h000186A0, 32'h000186A0, "techctl other mode");
    wr(32'h64, 32'h6);
    drv(32'h000186A0, 32'h00030D40, "hibernate");
    wr(32'h64, 32'h0);
    wr(32'h38, 32'h0);
  endtask
  task automatic t_skip;
    wr(32'h18, 32'h000927C0);
    wr(32'h30, 32'h00004E20);
    hold <= 1'b1;
    hold_val <= 32'h0007A120;
    drv(32'h00094ED0, 32'h0008D9A0, "lower edge");
    check({31'h0, skip_flag}, 32'h0, "flag clear");
    hold_val <= 32'h000AAE60;
    drv(32'h00094ED0, 32'h000975E0, "upper edge");
    hold_val <= 32'h000927C0;
    drv(32'h00094ED0, 32'h000975E0, "inside band");
    check({31'h0, skip_flag}, 32'h1, "flag set");
    rd(32'h2C, 32'h1, "flag reg");
    wr(32'h28, 32'h2);
    hold_val <= 32'h00030D40;
    drv(32'h0004BAF0, 32'h000445C0, "scaled band");
    wr(32'h08, 32'h2);
    e_pos <= 32'h0003D090;
    drv(32'h0004BAF0, 32'h0003D090, "limit after skip");
    wr(32'h08, 32'h1);
    wr(32'h28, 32'h1);
    hold <= 1'b0;
  endtask
  task automatic t_min;
    wr(32'h54, 32'h000186A0);
    wr(32'h34, 32'h1);
    drv(32'h0000C350, 32'h000186A0, "fixed min");
    check(aft_min, 32'h000186A0, "after min");
    wr(32'h34, 32'h2);
    drv(32'h0000C350, 32'h000249F0, "source min");
    rd(32'h48, 32'h000249F0, "after min reg");
    wr(32'h34, 32'h0);
  endtask
  task automatic t_lock;
    wr(32'h50, 32'h001E8480);
    wr(32'h00, 32'h00000001);
    check({31'h0, lock}, 32'h1, "lock pin set");
    rd(32'h58, 32'h1, "locked");
    repeat (3 * LOCKN) @(posedge hclk);
    rd(32'h58, 32'h0, "unlocked");
    check({31'h0, lock}, 32'h0, "lock pin clear");
    rd(32'h00, 32'h0C845880, "write refused");
    rd(32'h50, 32'h001E8480, "max taken");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    #400000;
    miscompares++;
    $display("MISMATCH %0t watchdog", $time);
    results;
  end
  initial begin
    {hresetn, hsel, hwrite, hold, e_sel, e_ninh, e_pinh, tc_b4, hib_b7} = '0;
    {htrans, haddr, hwdata, tot, e_neg, e_min, tc_out, hib_sp, hold_val} = '0;
    e_inv = 1'b1;
    tc_b4 = 1'b1;
    hib_b7 = 1'b1;
    tc_out = 32'h000493E0;
    hib_sp = 32'h00030D40;
    e_tot = 32'h00061A80;
    e_pos = 32'h000F4240;
    e_neg = 32'hFFF551A0;
    e_min = 32'h000249F0;
    e_scale = 16'h1388;
    pp = 8'h10;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_limits;
    t_dir;
    t_total;
    t_skip;
    t_min;
    t_lock;
    results;
  end
endmodule // ssl_top_bench
